// ---- hw/ogdc_guard.sv ----
// Functional notes
// - Enable input gates the final gate commands directly; low turns all off.
// - Watchdog supervises enable only when the watchdog bit is one.
// - In watchdog mode first enable edge activates outputs and starts timer.
// - Missing edge within timeout forces outputs low and sets timeout flag.
// - After timeout any enable edge reactivates outputs and restarts timer.
// - Timeout flag stays latched until software clears it or a wake from sleep clears it.
// - Reset input low beyond 200 us disables outputs and enters sleep.
// - Waking from sleep clears latched fault states and all fault flags.
// - After wake outputs stay off until charge pump settle time ends.
// - Overvoltage on reset pin sets the logic pin overvoltage flag.
// - Short reset pulse clears latched output-disabling faults.
// - Short reset pulse leaves status flags unchanged.
// - Gain code 0..6 gives 10..40 in steps of 5, code 7 gives 50.
// - Offset code decodes to output offset up to 2.5 V.
// - All diagnostics maskable except power-on, serial error, overtemperature.
// - Diagnostic select picks general, pulsed, temperature or offset output.
// - General flag is low while a fault or latched disable is present.
// - Pulsed mode: 100 ms period, 20 % duty on fault, 80 % otherwise.
// - Every register write loads the status word for shifting out.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
module ogdc_guard
   import ogdc_pkg::*;
#(
   parameter int unsigned ETO_CYCLES   = ETO_CYC,
   parameter int unsigned SLEEP_CYCLES = SLEEP_CYC,
   parameter int unsigned RST_CYCLES   = RST_CYC,
   parameter int unsigned CP_CYCLES    = CP_CYC,
   parameter int unsigned FP_CYCLES    = FP_CYC
) (
   input  wire logic                ref_clk_in,
   input  wire logic                nrst_in,
   input  wire ogdc_bus_req_s       bus_req_in,
   output logic [31:0]              bus_rdata_out,
   input  wire logic                enable_in,
   input  wire logic                sleep_reset_n_in,
   input  wire logic [3:0]          phase_cmd_in,
   input  wire logic [NUM_DIAG-1:0] diag_lvl_in,
   input  wire logic                latch_fault_in,
   output logic [3:0]               gate_out,
   output logic                     diag_pin_out,
   output logic [1:0]               diag_analog_sel_out,
   output logic [5:0]               sense_gain_out,
   output logic [11:0]              sense_offset_mv_out,
   output logic                     status_load_out,
   output logic [15:0]              status_word_out,
   output logic                     sleep_out
);
   localparam int unsigned CW = 32;

   // ****************************************
   // Decode functions.
   // ****************************************
   // Gain code to amplifier gain.
   function automatic logic [5:0] gain_dec(input logic [2:0] c);
      gain_dec = (c == 3'h7) ? 6'h32 : 6'(10 + 5 * c);
   endfunction

   // Offset code to offset in millivolts.
   function automatic logic [11:0] ofs_dec(input logic [3:0] c);
      case (c)
         4'h0, 4'h1: ofs_dec = 12'h000;
         4'h2, 4'h3: ofs_dec = 12'h064;
         4'h4: ofs_dec = 12'h0C8;
         4'h5: ofs_dec = 12'h12C;
         4'h6: ofs_dec = 12'h190;
         4'h7: ofs_dec = 12'h1F4;
         default: ofs_dec = 12'(750 + 250 * (c - 4'h8));
      endcase
   endfunction

   // ****************************************
   // Registers and state.
   // ****************************************
   logic [CFG_W-1:0]    cfg_r;
   logic [STATUS_W-1:0] mask_r;
   logic [STATUS_W-1:0] status_r;
   logic [STATUS_W-1:0] status_nxt;
   ogdc_wd_e            wd_r;
   ogdc_wd_e            wd_nxt;
   logic [CW-1:0]       wd_cnt_r;
   logic [CW-1:0]       wd_cnt_nxt;
   ogdc_pw_e            pw_r;
   ogdc_pw_e            pw_nxt;
   logic [CW-1:0]       low_cnt_r;
   logic [CW-1:0]       cp_cnt_r;
   logic [CW-1:0]       fp_cnt_r;
   logic                en_prev_r;
   logic                rst_prev_r;
   logic                lat_dis_r;
   logic [31:0]         rdata_nxt;

   // ****************************************
   // Bus decode.
   // ****************************************
   // Strobe and address decode.
   wire wr_cfg    = bus_req_in.wr && (bus_req_in.addr == ADDR_CFG);
   wire wr_mask   = bus_req_in.wr && (bus_req_in.addr == ADDR_MASK);
   wire wr_status = bus_req_in.wr && (bus_req_in.addr == ADDR_STATUS);

   // Configuration fields.
   wire       enable_watchdog_on    = cfg_r[CFG_EWD_BIT];
   wire [1:0] dg_sel = cfg_r[CFG_DG_LSB +: 2];
   wire [2:0] g_code = cfg_r[CFG_GAIN_LSB +: 3];
   wire [3:0] o_code = cfg_r[CFG_OFS_LSB +: 4];

   // Read data selection.
   always_comb begin
      if (bus_req_in.addr == ADDR_CFG) begin
         rdata_nxt = 32'(cfg_r);
      end else if (bus_req_in.addr == ADDR_MASK) begin
         rdata_nxt = 32'(mask_r);
      end else if (bus_req_in.addr == ADDR_STATUS) begin
         rdata_nxt = 32'(status_r);
      end else if (bus_req_in.addr == ADDR_SENSE) begin
         rdata_nxt = {14'h0000, sense_offset_mv_out, sense_gain_out};
      end else begin
         rdata_nxt = 32'h00000000;
      end
   end

   // ****************************************
   // Enable watchdog.
   // ****************************************
   // Enable edge and timeout terminal count.
   wire en_edge = enable_in ^ en_prev_r;
   wire wd_end  = (wd_cnt_r == CW'(ETO_CYCLES - 1));
   wire eto_evt = (wd_r == WD_RUN) && enable_watchdog_on && !en_edge && wd_end;

   // Watchdog state machine.
   always_comb begin
      wd_nxt = wd_r;
      wd_cnt_nxt = wd_cnt_r + CW'(1);
      case (wd_r)
         WD_IDLE: begin
            wd_cnt_nxt = '0;
            if (enable_watchdog_on && en_edge) begin
               wd_nxt = WD_RUN;
            end
         end
         WD_RUN: begin
            if (!enable_watchdog_on) begin
               wd_nxt = WD_IDLE;
            end else if (en_edge) begin
               wd_cnt_nxt = '0;
            end else if (wd_end) begin
               wd_nxt = WD_TRIP;
            end
         end
         WD_TRIP: begin
            wd_cnt_nxt = '0;
            if (!enable_watchdog_on) begin
               wd_nxt = WD_IDLE;
            end else if (en_edge) begin
               wd_nxt = WD_RUN;
            end
         end
         default: begin
            wd_nxt = WD_IDLE;
         end
      endcase
   end

   // ****************************************
   // Sleep, wake and fault-clear pulse.
   // ****************************************
   // Reset pin edge and qualification.
   wire rst_rise  = sleep_reset_n_in && !rst_prev_r;
   wire low_sat   = (low_cnt_r == CW'(SLEEP_CYCLES));
   wire wake      = rst_rise && (pw_r == PW_SLEEP);
   wire clr_pulse = rst_rise && (pw_r != PW_SLEEP)
                    && (low_cnt_r >= CW'(RST_CYCLES));

   // Power state machine.
   always_comb begin
      pw_nxt = pw_r;
      case (pw_r)
         PW_ACTIVE: begin
            if (low_sat) begin
               pw_nxt = PW_SLEEP;
            end
         end
         PW_SLEEP: begin
            if (wake) begin
               pw_nxt = PW_CPWAIT;
            end
         end
         PW_CPWAIT: begin
            if (low_sat) begin
               pw_nxt = PW_SLEEP;
            end else if (cp_cnt_r == CW'(CP_CYCLES - 1)) begin
               pw_nxt = PW_ACTIVE;
            end
         end
         default: begin
            pw_nxt = PW_ACTIVE;
         end
      endcase
   end

   // ****************************************
   // Gate output and status.
   // ****************************************
   // Final gate command, gated directly by the enable level.
   wire wd_ok    = !enable_watchdog_on || (wd_r == WD_RUN);
   wire drive_ok = enable_in && wd_ok && (pw_r == PW_ACTIVE) && !lat_dis_r;
   assign gate_out = phase_cmd_in & {4{drive_ok}};

   // Sticky flags: set wins over clear; wake clears every flag.
   wire [STATUS_W-1:0] set_v = {diag_lvl_in, eto_evt, 1'b0}
                               & ~mask_r;
   wire [STATUS_W-1:0] clr_v = wr_status ?
                               bus_req_in.wdata[STATUS_W-1:0] : '0;
   assign status_nxt = (status_r & ~clr_v & ~{STATUS_W{wake}}) | set_v;

   // Live fault summary for the diagnostic pin.
   wire lvl_fault = |(diag_lvl_in & ~mask_r[ST_LVL_LSB +: NUM_DIAG]);
   wire fault_any = lvl_fault || lat_dis_r || (wd_r == WD_TRIP);

   // Pulsed flag waveform.
   wire [CW-1:0] duty_cyc = fault_any ? CW'(FP_CYCLES * FP_DUTY_FLT / 100)
                                      : CW'(FP_CYCLES * FP_DUTY_OK / 100);
   wire fp_high = (fp_cnt_r < duty_cyc);
   wire fp_wrap = (fp_cnt_r == CW'(FP_CYCLES - 1));

   // Diagnostic pin level per selection.
   wire diag_nxt = (dg_sel == DG_GENERAL) ? !fault_any :
                   (dg_sel == DG_PULSED)  ? fp_high : 1'b1;

   // ****************************************
   // Flip-flops.
   // ****************************************
   // Software registers and read data.
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cfg_r <= CFG_RST;
         mask_r <= MASK_RST;
         status_r <= STATUS_RST;
         bus_rdata_out <= 32'h00000000;
      end else begin
         if (wr_cfg) begin
            cfg_r <= bus_req_in.wdata[CFG_W-1:0];
         end
         if (wr_mask) begin
            mask_r <= bus_req_in.wdata[STATUS_W-1:0] & ~UNMASKABLE;
         end
         status_r <= status_nxt;
         bus_rdata_out <= bus_req_in.rd ? rdata_nxt : 32'h00000000;
      end
   end

   // Watchdog and power state registers.
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wd_r <= WD_IDLE;
         wd_cnt_r <= '0;
         pw_r <= PW_ACTIVE;
         en_prev_r <= 1'b0;
         rst_prev_r <= 1'b1;
      end else begin
         wd_r <= wd_nxt;
         wd_cnt_r <= wd_cnt_nxt;
         pw_r <= pw_nxt;
         en_prev_r <= enable_in;
         rst_prev_r <= sleep_reset_n_in;
      end
   end

   // Counters for reset low time, charge pump settle and pulse period.
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         low_cnt_r <= '0;
         cp_cnt_r <= '0;
         fp_cnt_r <= '0;
      end else begin
         low_cnt_r <= (sleep_reset_n_in || low_sat) ?
                      (sleep_reset_n_in ? '0 : low_cnt_r) : low_cnt_r + CW'(1);
         cp_cnt_r <= (pw_r == PW_CPWAIT) ? cp_cnt_r + CW'(1) : '0;
         fp_cnt_r <= fp_wrap ? '0 : fp_cnt_r + CW'(1);
      end
   end

   // Latched output disable: set by a latched fault, cleared by pulse or wake.
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lat_dis_r <= 1'b0;
      end else begin
         lat_dis_r <= latch_fault_in || (lat_dis_r && !clr_pulse && !wake);
      end
   end

   // Outputs from flip-flops.
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         diag_pin_out <= 1'b1;
         diag_analog_sel_out <= 2'b00;
         sense_gain_out <= 6'h0A;
         sense_offset_mv_out <= 12'h000;
         status_load_out <= 1'b0;
         status_word_out <= 16'h0000;
         sleep_out <= 1'b0;
      end else begin
         diag_pin_out <= diag_nxt;
         diag_analog_sel_out <= dg_sel;
         sense_gain_out <= gain_dec(g_code);
         sense_offset_mv_out <= ofs_dec(o_code);
         status_load_out <= bus_req_in.wr;
         if (bus_req_in.wr) begin
            status_word_out <= {|status_r, 5'h00, status_r};
         end
         sleep_out <= (pw_r == PW_SLEEP);
      end
   end

   // ****************************************
   // Assertions.
   // ****************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   a_gate_enable_low: assert property (!enable_in |-> gate_out == 4'h0)
      else $error("Gate active with enable low.");
   a_wd_off_idle: assert property (!enable_watchdog_on |=> wd_r == WD_IDLE)
      else $error("Watchdog active while disabled.");
   a_wd_first_edge: assert property (enable_watchdog_on && wd_r == WD_IDLE && en_edge
      |=> wd_r == WD_RUN && wd_cnt_r == '0)
      else $error("First enable edge did not start watchdog.");
   a_wd_trip_kill: assert property (eto_evt |=> gate_out == 4'h0
      && status_r[ST_ETO] == !mask_r[ST_ETO])
      else $error("Timeout did not kill outputs or set flag.");
   a_wd_rearm: assert property (enable_watchdog_on && wd_r == WD_TRIP && en_edge
      |=> wd_r == WD_RUN)
      else $error("Enable edge did not rearm outputs.");
   a_eto_sticky: assert property (status_r[ST_ETO] && !wr_status && !wake
      |=> status_r[ST_ETO])
      else $error("Timeout flag lost without clear.");
   a_sleep_off: assert property (low_sat && !sleep_reset_n_in
      |=> ##1 gate_out == 4'h0 && sleep_out)
      else $error("Sleep not entered after long reset low.");
   a_wake_clear: assert property (wake |=> !lat_dis_r
      && (status_r & ~$past(set_v)) == '0
      && pw_r == PW_CPWAIT)
      else $error("Wake did not clear faults.");
   a_cp_hold: assert property (pw_r == PW_CPWAIT |-> gate_out == 4'h0)
      else $error("Gate active before charge pump ready.");
   a_wake_gate_off: assert property (wake |=> gate_out == 4'h0)
      else $error("Gate active right after wake.");
   a_trip_hold: assert property (wd_r == WD_TRIP && enable_watchdog_on |-> gate_out == 4'h0)
      else $error("Gate active during watchdog trip.");
   a_vlo_flag: assert property (diag_lvl_in[ST_VLO - ST_LVL_LSB]
      && !mask_r[ST_VLO] |=> status_r[ST_VLO])
      else $error("Logic pin overvoltage flag not set.");
   a_pulse_keeps: assert property (clr_pulse && !wr_status
      |=> (status_r & $past(status_r)) == $past(status_r)
      && (lat_dis_r == $past(latch_fault_in)))
      else $error("Fault clear pulse misbehaved.");
   a_mask_fixed: assert property ((mask_r & UNMASKABLE) == '0)
      else $error("Unmaskable diagnostic masked.");
   a_diag_general: assert property (dg_sel == DG_GENERAL && $stable(dg_sel)
      |=> diag_pin_out == !$past(fault_any))
      else $error("General fault flag wrong.");
   a_status_load: assert property (bus_req_in.wr
      |=> status_load_out && status_word_out[SER_FF_BIT] == |$past(status_r))
      else $error("Status word not loaded on write.");

   c_wd_trip: cover property (eto_evt);
   c_wake: cover property (wake);
   c_clr_pulse: cover property (clr_pulse && lat_dis_r);
   c_pulsed: cover property (dg_sel == DG_PULSED && fp_wrap);
   c_sleep: cover property (sleep_out && !sleep_reset_n_in);
endmodule

// ---- shared/ogdc_pkg.sv ----
// ****************************************
// Output guard and diagnostic constants.
// ****************************************
package ogdc_pkg;
   // Clock and documented times.
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned ETO_PERIOD_MS  = 50;
   localparam int unsigned SLEEP_ENTRY_US = 200;
   localparam int unsigned RST_PULSE_US   = 10;
   localparam int unsigned CP_SETTLE_MS   = 3;
   localparam int unsigned FP_PERIOD_MS   = 100;
   localparam int unsigned FP_DUTY_FLT    = 20;
   localparam int unsigned FP_DUTY_OK     = 80;
   // Cycle counts derived from the times.
   localparam int unsigned ETO_CYC   = ETO_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_CYC =
      (SLEEP_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RST_CYC   =
      (RST_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CP_CYC    =
      (CP_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FP_CYC    = FP_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   // Register byte addresses.
   localparam logic [3:0] ADDR_CFG    = 4'h0;
   localparam logic [3:0] ADDR_MASK   = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_SENSE  = 4'hC;
   // Configuration fields.
   localparam int unsigned CFG_EWD_BIT  = 0;
   localparam int unsigned CFG_DG_LSB   = 1;
   localparam int unsigned CFG_GAIN_LSB = 3;
   localparam int unsigned CFG_OFS_LSB  = 6;
   localparam int unsigned CFG_W        = 10;
   localparam logic [9:0]  CFG_RST      = 10'h000;
   // Status layout: level diagnostics sit from ST_LVL_LSB up.
   localparam int unsigned NUM_DIAG   = 8;
   localparam int unsigned ST_POR     = 0;
   localparam int unsigned ST_ETO     = 1;
   localparam int unsigned ST_LVL_LSB = 2;
   localparam int unsigned ST_OT      = 2;
   localparam int unsigned ST_SE      = 3;
   localparam int unsigned ST_VLO     = 4;
   localparam int unsigned STATUS_W   = 10;
   localparam logic [9:0]  STATUS_RST = 10'h001;
   localparam logic [9:0]  UNMASKABLE = 10'h00D;
   localparam logic [9:0]  MASK_RST   = 10'h000;
   localparam int unsigned SER_FF_BIT = 15;
   // Diagnostic pin selections.
   typedef enum logic [1:0] {
      DG_GENERAL = 2'b00,
      DG_PULSED  = 2'b01,
      DG_TEMP    = 2'b10,
      DG_OFFSET  = 2'b11
   } ogdc_dg_e;
   // Watchdog states.
   typedef enum logic [1:0] {
      WD_IDLE = 2'b00,
      WD_RUN  = 2'b01,
      WD_TRIP = 2'b10
   } ogdc_wd_e;
   // Power states.
   typedef enum logic [1:0] {
      PW_ACTIVE = 2'b00,
      PW_SLEEP  = 2'b01,
      PW_CPWAIT = 2'b10
   } ogdc_pw_e;
   // Register port request.
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ogdc_bus_req_s;
endpackage

// ---- verif/ogdc_mcu_model.sv ----
`timescale 1ns/100ps
// ****************************************
// Controller model driving the enable and sleep pins.
// ****************************************
module ogdc_mcu_model (
   input  wire logic ref_clk_in,
   output logic      enable_out,
   output logic      sleep_reset_n_out
);
   // Pins start idle: enable low, sleep pin driven high by the model.
   initial begin
      enable_out        = 1'b0;
      sleep_reset_n_out = 1'b1;
   end

   // Sets the enable level right after the next edge.
   task automatic set_en(input logic v);
      @(posedge ref_clk_in);
      enable_out <= v;
   endtask

   // Feeds the watchdog with n toggles; a gap near the timeout models a slow controller.
   task automatic feed(input int n, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge ref_clk_in);
         enable_out <= ~enable_out;
      end
   endtask

   // Drives the sleep pin level right after the next edge.
   task automatic set_sleep_n(input logic v);
      @(posedge ref_clk_in);
      sleep_reset_n_out <= v;
   endtask
endmodule

// ---- verif/tb_output_guard_and_diag_control.sv ----
`timescale 1ns/100ps
module tb_output_guard_and_diag_control;
   import ogdc_pkg::*;
   // ****************************************
   // Signals, clock and instances.
   // ****************************************
   logic                ref_clk_in;
   logic                nrst_in;
   ogdc_bus_req_s       bus_req;
   logic [3:0]          phase_cmd;
   logic [NUM_DIAG-1:0] diag_lvl;
   logic                latch_flt;
   logic                enable;
   logic                sleep_n;
   logic [31:0]         rdata;
   logic [3:0]          gate;
   logic                diag_pin;
   logic [1:0]          diag_sel;
   logic [5:0]          gain;
   logic [11:0]         offset_mv;
   logic                st_load;
   logic [15:0]         st_word;
   logic                sleep;
   int                  miscompares = 0;
   int                  compares    = 0;
   int                  cycles      = 0;

   // Free-running 100 MHz clock.
   always #5 ref_clk_in = ~ref_clk_in;

   // Cuts a hang short well beyond the expected run length.
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   ogdc_guard #(
      .ETO_CYCLES   (20),
      .SLEEP_CYCLES (40),
      .RST_CYCLES   (5),
      .CP_CYCLES    (10),
      .FP_CYCLES    (20)
   ) i_ogdc_guard (
      .ref_clk_in          (ref_clk_in),
      .nrst_in             (nrst_in),
      .bus_req_in          (bus_req),
      .bus_rdata_out       (rdata),
      .enable_in           (enable),
      .sleep_reset_n_in    (sleep_n),
      .phase_cmd_in        (phase_cmd),
      .diag_lvl_in         (diag_lvl),
      .latch_fault_in      (latch_flt),
      .gate_out            (gate),
      .diag_pin_out        (diag_pin),
      .diag_analog_sel_out (diag_sel),
      .sense_gain_out      (gain),
      .sense_offset_mv_out (offset_mv),
      .status_load_out     (st_load),
      .status_word_out     (st_word),
      .sleep_out           (sleep)
   );

   ogdc_mcu_model i_ogdc_mcu_model (
      .ref_clk_in        (ref_clk_in),
      .enable_out        (enable),
      .sleep_reset_n_out (sleep_n)
   );

   // ****************************************
   // Shared tasks.
   // ****************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_in);
      bus_req.wr <= 1'b0;
   endtask

   // One-cycle register read; data is taken in the following cycle only.
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk_in);
      bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_in);
      bus_req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Lets n edges pass and samples just after the last one.
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask

   // Counts high cycles of the diagnostic pin over one pulse period.
   task automatic count_high(output int n);
      n = 0;
      repeat (20) begin
         @(posedge ref_clk_in);
         #1 if (diag_pin === 1'b1) n++;
      end
   endtask

   // ****************************************
   // Scenarios.
   // ****************************************
   // Reset values at the pins and in the status register.
   task automatic t_reset();
      logic [31:0] d;
      rd(ADDR_STATUS, d);
      chk("status_reset", 32'h0000_0001, d);
      chk("diag_pin_reset", 32'h1, {31'h0, diag_pin});
      chk("gain_reset", 32'hA, {26'h0, gain});
   endtask

   // Enable gates the phase commands directly, in the same cycle.
   task automatic t_enable();
      i_ogdc_mcu_model.set_en(1'b1);
      #1 chk("gate_en_hi", 32'hA, {28'h0, gate});
      @(posedge ref_clk_in);
      phase_cmd <= 4'h5;
      #1 chk("gate_phase", 32'h5, {28'h0, gate});
      i_ogdc_mcu_model.set_en(1'b0);
      #1 chk("gate_en_lo", 32'h0, {28'h0, gate});
      phase_cmd <= 4'hA;
   endtask

   // Every gain and offset code, at the pins and in the sense register.
   task automatic t_sense();
      logic [31:0] d;
      int          g;
      int          o;
      for (int i = 0; i < 16; i++) begin
         g = (i % 8 == 7) ? 50 : 10 + 5 * (i % 8);
         o = (i < 2) ? 0 : (i < 4) ? 100 : (i < 8) ? (i - 2) * 100 : 750 + 250 * (i - 8);
         wr(ADDR_CFG, (i << CFG_OFS_LSB) | ((i % 8) << CFG_GAIN_LSB));
         settle(2);
         chk("gain", g, {26'h0, gain});
         chk("offset", o, {20'h0, offset_mv});
         rd(ADDR_SENSE, d);
         chk("sense_reg", (o << 6) | g, d);
      end
   endtask

   // Each diagnostic selection reaches the analog mux; analog picks park the pin high.
   task automatic t_diag_sel();
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_CFG, s << CFG_DG_LSB);
         settle(2);
         chk("diag_sel", s, {30'h0, diag_sel});
         if (s != 1) chk("diag_pin_sel", 32'h1, {31'h0, diag_pin});
      end
   endtask

   // Mask bits for power-on, serial error and overtemperature cannot be set.
   task automatic t_mask();
      logic [31:0] d;
      wr(ADDR_CFG, 32'h0);
      wr(ADDR_MASK, 32'h3FF);
      rd(ADDR_MASK, d);
      chk("mask_reg", 32'h3F2, d);
      @(posedge ref_clk_in);
      diag_lvl <= 8'h04;
      settle(3);
      chk("diag_pin_masked", 32'h1, {31'h0, diag_pin});
      rd(ADDR_STATUS, d);
      chk("overvolt_masked", 32'h0, {31'h0, d[ST_VLO]});
      diag_lvl <= 8'h01;
      settle(3);
      chk("diag_pin_overtemp", 32'h0, {31'h0, diag_pin});
      diag_lvl <= 8'h00;
      wr(ADDR_MASK, 32'h0);
      diag_lvl <= 8'h04;
      settle(2);
      rd(ADDR_STATUS, d);
      chk("overvolt_flag", 32'h1, {31'h0, d[ST_VLO]});
      diag_lvl <= 8'h00;
   endtask

   // Watchdog off, arming, feeding, timeout, recovery and flag clearing.
   task automatic t_watchdog();
      logic [31:0] st;
      i_ogdc_mcu_model.set_en(1'b1);
      settle(30);
      chk("gate_no_wd", 32'hA, {28'h0, gate});
      wr(ADDR_STATUS, 32'h3FF);
      wr(ADDR_CFG, 32'h1);
      settle(2);
      chk("gate_armed", 32'h0, {28'h0, gate});
      i_ogdc_mcu_model.feed(2, 2);
      settle(2);
      chk("gate_first_edge", 32'hA, {28'h0, gate});
      i_ogdc_mcu_model.feed(6, 10);
      rd(ADDR_STATUS, st);
      chk("gate_fed", 32'hA, {28'h0, gate});
      chk("eto_fed", 32'h0, {31'h0, st[ST_ETO]});
      settle(25);
      chk("gate_trip", 32'h0, {28'h0, gate});
      rd(ADDR_STATUS, st);
      chk("eto_set", 32'h1, {31'h0, st[ST_ETO]});
      i_ogdc_mcu_model.feed(2, 2);
      settle(2);
      chk("gate_rearm", 32'hA, {28'h0, gate});
      rd(ADDR_STATUS, st);
      chk("eto_latched", 32'h1, {31'h0, st[ST_ETO]});
      wr(ADDR_STATUS, 32'h2);
      #1 chk("status_load", 32'h1, {31'h0, st_load});
      chk("status_word", {16'h0, |st[9:0], 5'h00, st[9:0]}, {16'h0, st_word});
      rd(ADDR_STATUS, st);
      chk("eto_cleared", 32'h0, {31'h0, st[ST_ETO]});
      wr(ADDR_CFG, 32'h0);
   endtask

   // Pulsed diagnostic duty, latched disable and its clearing by a short pulse.
   task automatic t_latch();
      logic [31:0] st0;
      logic [31:0] st1;
      int          n;
      wr(ADDR_CFG, 32'h2);
      count_high(n);
      chk("pulse_ok_duty", 32'h1, {31'h0, n > 10});
      @(posedge ref_clk_in);
      latch_flt <= 1'b1;
      @(posedge ref_clk_in);
      latch_flt <= 1'b0;
      settle(1);
      chk("gate_latched", 32'h0, {28'h0, gate});
      count_high(n);
      chk("pulse_flt_duty", 32'h1, {31'h0, n < 10});
      wr(ADDR_CFG, 32'h0);
      settle(2);
      chk("diag_pin_latched", 32'h0, {31'h0, diag_pin});
      diag_lvl <= 8'h80;
      @(posedge ref_clk_in);
      diag_lvl <= 8'h00;
      rd(ADDR_STATUS, st0);
      chk("status_before", 32'h200, st0);
      i_ogdc_mcu_model.set_sleep_n(1'b0);
      settle(8);
      i_ogdc_mcu_model.set_sleep_n(1'b1);
      settle(3);
      chk("gate_cleared", 32'hA, {28'h0, gate});
      chk("diag_pin_cleared", 32'h1, {31'h0, diag_pin});
      chk("sleep_short", 32'h0, {31'h0, sleep});
      rd(ADDR_STATUS, st1);
      chk("status_kept", st0, st1);
   endtask

   // Sleep entry, wake clearing the flags, and the charge pump wait.
   task automatic t_sleep();
      logic [31:0] st;
      i_ogdc_mcu_model.set_sleep_n(1'b0);
      settle(50);
      chk("sleep_entered", 32'h1, {31'h0, sleep});
      chk("gate_sleep", 32'h0, {28'h0, gate});
      i_ogdc_mcu_model.set_sleep_n(1'b1);
      settle(3);
      chk("gate_cp_wait", 32'h0, {28'h0, gate});
      rd(ADDR_STATUS, st);
      chk("status_wake", 32'h0, st);
      settle(15);
      chk("gate_awake", 32'hA, {28'h0, gate});
      chk("sleep_left", 32'h0, {31'h0, sleep});
   endtask

   // Main sequence: reset for three cycles, then every scenario in turn.
   initial begin
      ref_clk_in = 1'b0;
      nrst_in <= 1'b0;
      bus_req <= '0;
      phase_cmd <= 4'hA;
      diag_lvl <= 8'h00;
      latch_flt <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_enable();
      t_sense();
      t_diag_sel();
      t_mask();
      t_watchdog();
      t_latch();
      t_sleep();
      test_done();
   end
endmodule
